// File: shared/lsdsr_cfg.svh
// constants for the long serial delay shift register
`ifndef LSDSR_CFG_SVH
`define LSDSR_CFG_SVH
`define LSDSR_STAGES 200
`define LSDSR_SYNC_RST 6'h00
`define LSDSR_PIN_SEL 0
`define LSDSR_PIN_SCLK 1
`define LSDSR_PIN_PH1 2
`define LSDSR_PIN_PH2 3
`define LSDSR_PIN_DIN 4
`define LSDSR_PIN_PRE 5
`define LSDSR_BUF_DEPTH 2'h2
`define LSDSR_PRESET_ONES 1'h1
`endif

// File: shared/lsdsr_pkg.sv
// types for the long serial delay shift register
package lsdsr_pkg;
  typedef enum logic [1:0] {
    LSDSR_RUN,
    LSDSR_PRESET
  } lsdsr_state_t;
endpackage : lsdsr_pkg

// File: rtl/lsdsr_top.sv
// long serial delay shift register with single or two-phase shift clocking
`include "lsdsr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module lsdsr_top #(
  parameter int STAGES = `LSDSR_STAGES
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // pins from the driving party
  input wire logic clock_phase_select,
  input wire logic single_phase_shift_clock,
  input wire logic phase_one_clock,
  input wire logic phase_two_clock,
  input wire logic serial_in,
  // preset request, value chosen by preset_ones
  input wire logic preset_req,
  input wire logic preset_ones,
  // serial output through a two-entry buffer
  output logic serial_out,
  output logic serial_out_valid,
  input wire logic serial_out_ready,
  output logic shift_stall,
  // delayed clocks for a cascaded register
  output logic delayed_phase_one_out,
  output logic delayed_phase_two_out
);
  localparam int CW = $clog2(STAGES + 1);
  // two-flop synchronisers for every pin but preset_req and serial_out_ready
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  wire [5:0] pin_raw = {preset_ones, serial_in, phase_two_clock, phase_one_clock,
                        single_phase_shift_clock, clock_phase_select};
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_q <= `LSDSR_SYNC_RST;
      pin_s2_q <= `LSDSR_SYNC_RST;
    end else if (clk_en) begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end
  wire mode_two = pin_s2_q[`LSDSR_PIN_SEL];
  wire sp_clk_raw = pin_s2_q[`LSDSR_PIN_SCLK];
  wire ph1 = pin_s2_q[`LSDSR_PIN_PH1];
  wire ph2 = pin_s2_q[`LSDSR_PIN_PH2];
  wire din = pin_s2_q[`LSDSR_PIN_DIN];
  wire pre_val = pin_s2_q[`LSDSR_PIN_PRE];
  // internal pull-down active in two-phase mode
  wire sp_clk = sp_clk_raw & ~mode_two;
  // derived phases: single clock high is phase one, low is phase two
  wire int_ph1 = mode_two ? ph1 : sp_clk;
  wire int_ph2 = mode_two ? ph2 : ~sp_clk;
  logic ph1_q;
  always_ff @(posedge clk) begin
    if (rst) ph1_q <= 1'h0;
    else if (clk_en) ph1_q <= int_ph1;
  end
  // one rising edge of phase one (or the single clock) means one shift
  wire shift_edge = int_ph1 & ~ph1_q;
  // output buffer
  logic [1:0] buf_q;
  logic [1:0] cnt_q;
  wire buf_full = (cnt_q == `LSDSR_BUF_DEPTH);
  lsdsr_pkg::lsdsr_state_t state_q;
  wire pop = serial_out_valid & serial_out_ready;
  // a full buffer holds the chain; a dropped edge is the cost of no lost word
  wire do_shift = shift_edge & ~buf_full & (state_q == lsdsr_pkg::LSDSR_RUN);
  // chain and preset sequencer
  logic [STAGES-1:0] chain_q;
  logic [CW-1:0] fill_q;
  logic [CW-1:0] pre_cnt_q;
  logic pre_bit_q;
  wire pre_done = (pre_cnt_q == CW'(STAGES - 1));
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= lsdsr_pkg::LSDSR_RUN;
      pre_cnt_q <= '0;
      pre_bit_q <= 1'h0;
    end else if (clk_en) begin
      unique case (state_q)
        lsdsr_pkg::LSDSR_RUN: if (preset_req) begin
          state_q <= lsdsr_pkg::LSDSR_PRESET;
          pre_cnt_q <= '0;
          pre_bit_q <= pre_val;
        end
        lsdsr_pkg::LSDSR_PRESET: begin
          pre_cnt_q <= pre_cnt_q + CW'(1);
          if (pre_done) state_q <= lsdsr_pkg::LSDSR_RUN;
        end
      endcase
    end
  end
  wire in_pre = (state_q == lsdsr_pkg::LSDSR_PRESET);
  always_ff @(posedge clk) begin
    if (rst) begin
      chain_q <= '0;
      fill_q <= '0;
    end else if (clk_en) begin
      if (in_pre) begin
        // ripple the preset level one stage per cycle
        chain_q <= {chain_q[STAGES-2:0], pre_bit_q};
      end else if (do_shift) begin
        chain_q <= {chain_q[STAGES-2:0], din};
        if (fill_q != CW'(STAGES)) fill_q <= fill_q + CW'(1);
      end
    end
  end
  // last stage leaves on each shift once the chain has filled
  wire push = do_shift & (fill_q == CW'(STAGES));
  wire last_bit = chain_q[STAGES-1];
  always_ff @(posedge clk) begin
    if (rst) begin
      buf_q <= 2'h0;
      cnt_q <= 2'h0;
    end else if (clk_en) begin
      if (pop) begin
        buf_q[0] <= buf_full ? buf_q[1] : last_bit;
      end else if (push && cnt_q == 2'h0) begin
        buf_q[0] <= last_bit;
      end
      if (push && (cnt_q - 2'(pop)) == 2'h1) buf_q[1] <= last_bit;
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
    end
  end
  assign serial_out = buf_q[0];
  // outputs from flops
  logic valid_q;
  logic stall_q;
  logic d1_q;
  logic d2_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      valid_q <= 1'h0;
      stall_q <= 1'h0;
      d1_q <= 1'h0;
      d2_q <= 1'h0;
    end else if (clk_en) begin
      valid_q <= (cnt_q + 2'(push) - 2'(pop)) != 2'h0;
      stall_q <= ((cnt_q + 2'(push) - 2'(pop)) == `LSDSR_BUF_DEPTH) | in_pre;
      d1_q <= int_ph1;
      d2_q <= int_ph2;
    end
  end
  assign serial_out_valid = valid_q;
  assign shift_stall = stall_q;
  assign delayed_phase_one_out = d1_q;
  assign delayed_phase_two_out = d2_q;

  // checks
  property p_no_overflow;
    @(posedge clk) disable iff (rst) cnt_q != 2'h3;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("buffer overflow");
  property p_shift_moves;
    @(posedge clk) disable iff (rst) (clk_en && do_shift && !in_pre)
      |=> chain_q[0] == $past(din);
  endproperty
  a_shift_moves: assert property (p_shift_moves) else $error("input not captured");
  property p_pulldown;
    @(posedge clk) disable iff (rst) mode_two |-> !sp_clk;
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down missing");
  property p_two_phase_edge;
    @(posedge clk) disable iff (rst) (mode_two && !(ph1 && !ph1_q)) |-> !do_shift;
  endproperty
  a_two_phase_edge: assert property (p_two_phase_edge) else $error("shift off phase one");
  property p_delayed;
    @(posedge clk) disable iff (rst) clk_en |=> delayed_phase_one_out == $past(int_ph1);
  endproperty
  a_delayed: assert property (p_delayed) else $error("delayed clock wrong");
  property p_preset_end;
    @(posedge clk) disable iff (rst) (in_pre && pre_done && clk_en)
      |=> chain_q[0] == pre_bit_q && !in_pre;
  endproperty
  a_preset_end: assert property (p_preset_end) else $error("preset not applied");
  // one shift per rising phase-one edge while the chain is free
  sequence s_ph1_rise;
    clk_en && !int_ph1 ##1 int_ph1;
  endsequence
  property p_shift_on_rise;
    @(posedge clk) disable iff (rst) s_ph1_rise ##0 (!buf_full && !in_pre) |-> do_shift;
  endproperty
  a_shift_on_rise: assert property (p_shift_on_rise) else $error("edge lost");
  // after the last ripple cycle every stage holds the preset level
  sequence s_preset_last;
    in_pre && pre_done && clk_en;
  endsequence
  property p_preset_all;
    @(posedge clk) disable iff (rst) s_preset_last |=> chain_q == {STAGES{pre_bit_q}};
  endproperty
  a_preset_all: assert property (p_preset_all) else $error("stage not preset");
  // a buffered word waits, unchanged, for the receiver
  property p_out_holds;
    @(posedge clk) disable iff (rst) (clk_en && serial_out_valid && !serial_out_ready)
      |=> serial_out_valid && $stable(serial_out);
  endproperty
  a_out_holds: assert property (p_out_holds) else $error("output moved");
  // the word entering an empty buffer is the one leaving the last stage
  property p_push_last;
    @(posedge clk) disable iff (rst) (clk_en && push && cnt_q == 2'h0)
      |=> serial_out == $past(last_bit) && serial_out_valid;
  endproperty
  a_push_last: assert property (p_push_last) else $error("wrong stage output");
  // single-clock mode drives the delayed pair as opposite phases
  property p_single_pair;
    @(posedge clk) disable iff (rst) (clk_en && !mode_two)
      |=> delayed_phase_two_out != delayed_phase_one_out;
  endproperty
  a_single_pair: assert property (p_single_pair) else $error("phases not paired");
endmodule : lsdsr_top
`default_nettype wire

// File: verif/lsdsr_drv.sv
// upstream driver model: phase select, shift clocks and serial data
`timescale 1ns/1ps
`default_nettype none
module lsdsr_drv (
  // clock
  input wire logic clk,
  // pins toward the register
  output logic sel,
  output logic sclk,
  output logic p1,
  output logic p2,
  output logic din
);
  initial begin
    {sel, sclk, p1, p2, din} = 5'h00;
  end
  // idle first so the synchronised select settles before any edge
  task automatic shift_bit(input logic two, input logic b);
    // fixed twelve-cycle bit period keeps the shift rate up
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      sel = two;
      din = (i == 11) ? ~b : b;
      p1 = two && i inside {[4:7]};
      p2 = two && i > 7;
      sclk = two ? (i > 3 && i[0]) : i inside {[3:8]};
    end
  endtask : shift_bit
endmodule : lsdsr_drv
`default_nettype wire

// File: verif/testbench.sv
// testbench: streams, stall and preset on an 8-stage register
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'h0, rst = 1'h1, ready = 1'h1, pre_req = 1'h0, pre_ones = 1'h0;
  logic sel, sclk, p1, p2, din, sout, sval, stall, d1, d2;
  int failures = 0, tests_run = 0;
  logic chain_q[$];
  logic exp_q[$];
  always #2 clk = ~clk;
  lsdsr_drv u_drv (.clk(clk), .sel(sel), .sclk(sclk), .p1(p1), .p2(p2), .din(din));
  lsdsr_top #(.STAGES(8)) u_dut (.clk(clk), .rst(rst), .clk_en(1'h1),
    .clock_phase_select(sel), .single_phase_shift_clock(sclk), .phase_one_clock(p1),
    .phase_two_clock(p2), .serial_in(din), .preset_req(pre_req), .preset_ones(pre_ones),
    .serial_out(sout), .serial_out_valid(sval), .serial_out_ready(ready),
    .shift_stall(stall), .delayed_phase_one_out(d1), .delayed_phase_two_out(d2));
  task automatic chk(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : chk
  task give_verdict;
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    if (!rst && sval === 1'h1 && ready) begin
      chk(sout, exp_q.size() ? exp_q.pop_front() : 1'hX, "output bit");
    end
  end
  // model first: the word may leave before the pulse ends
  task automatic push(input logic two, input logic b);
    chain_q.push_back(b);
    if (chain_q.size() > 8) exp_q.push_back(chain_q.pop_front());
    u_drv.shift_bit(two, b);
  endtask : push
  task automatic drain;
    for (int i = 0; i < 40 && exp_q.size() != 0; i++) @(negedge clk);
    if (exp_q.size() != 0) begin
      failures++;
      give_verdict();
    end
  endtask : drain
  task automatic sc_stream(input logic two);
    for (int k = 0; k < 12; k++) push(two, k[0] ^ k[2]);
    drain();
  endtask : sc_stream
  task automatic sc_stall;
    @(negedge clk) ready = 1'h0;
    push(1'h0, 1'h1);
    push(1'h0, 1'h0);
    repeat (4) @(negedge clk);
    chk(stall, 1'h1, "stall when buffer full");
    ready = 1'h1;
    drain();
    @(negedge clk) chk(stall, 1'h0, "stall cleared");
  endtask : sc_stall
  task automatic sc_preset(input logic v);
    @(negedge clk) pre_ones = v;
    repeat (3) @(negedge clk);
    pre_req = 1'h1;
    @(negedge clk) pre_req = 1'h0;
    repeat (12) @(negedge clk);
    foreach (chain_q[k]) chain_q[k] = v;
    sc_stream(1'h1);
  endtask : sc_preset
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'h0;
    sc_stream(1'h0);
    sc_stall();
    sc_preset(1'h1);
    sc_preset(1'h0);
    sc_stream(1'h0);
    repeat (4) @(negedge clk);
    chk(d1, 1'h0, "delayed phase one idle");
    chk(d2, 1'h1, "delayed phase two idle");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
